/* File: rtl/dpx_top.sv */
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "dpx_consts.svh"

module dpx_top (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  // classification request
  input  wire logic                     req_valid,
  input  wire dpx_pkg::dpx_op_t         req_op,
  input  wire logic [`DPX_RND_W-1:0]    csr_round,
  // classification answer
  output logic                          res_valid,
  output logic [`DPX_EXC_W-1:0]         res_mask,
  output logic [`DPX_RND_W-1:0]         res_round,
  output logic                          res_sets_flags,
  output logic                          res_dest_gpr,
  output logic                          res_unknown,
  // register port
  input  wire logic [`DPX_AW-1:0]       reg_addr,
  input  wire logic [`DPX_DW-1:0]       reg_wdata,
  input  wire logic                     reg_we,
  input  wire logic                     reg_re,
  output logic [`DPX_DW-1:0]            reg_rdata,
  // interrupt
  output logic                          irq
);
  import dpx_pkg::*;

  // =====================================================================
  // declarations
  dpx_cls_if cls ();

  logic                  res_valid_r;
  logic [`DPX_EXC_W-1:0] res_mask_r;
  logic [`DPX_RND_W-1:0] res_round_r;
  logic                  res_flags_r;
  logic                  res_gpr_r;
  logic                  res_unknown_r;
  logic [`DPX_DW-1:0]    ctrl_r;
  logic [`DPX_EXC_W-1:0] last_mask_r;
  dpx_op_t               last_op_r;
  logic [`DPX_DW-1:0]    rdata_r;
  logic [`DPX_DW-1:0]    rdata_nxt;
  logic [`DPX_EV_W-1:0]  ev_status;
  logic [`DPX_EV_W-1:0]  ev_enable;
  logic [`DPX_EV_W-1:0]  ev;

  // =====================================================================
  // decode
  assign cls.op = req_op;

  dpx_decode u_decode (
    .cls (cls)
  );

  wire enabled   = ctrl_r[`DPX_CTRL_EN];
  wire req_taken = req_valid && enabled;
  wire [`DPX_EXC_W-1:0] mask_nxt = cls.info.known ? cls.info.mask : `DPX_M_NONE;
  // truncating forms ignore the programmed rounding field
  wire [`DPX_RND_W-1:0] round_nxt = cls.info.chop ? `DPX_RND_CHOP : csr_round;

  // =====================================================================
  // answer registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      res_valid_r   <= 1'b0;
      res_mask_r    <= `DPX_M_NONE;
      res_round_r   <= `DPX_RND_RST;
      res_flags_r   <= 1'b0;
      res_gpr_r     <= 1'b0;
      res_unknown_r <= 1'b0;
    end else begin
      res_valid_r <= req_taken;
      if (req_taken) begin
        res_mask_r    <= mask_nxt;
        res_round_r   <= round_nxt;
        res_flags_r   <= cls.info.known && cls.info.sets_flags;
        res_gpr_r     <= cls.info.known && cls.info.dest_gpr;
        res_unknown_r <= !cls.info.known;
      end
    end
  end

  assign res_valid      = res_valid_r;
  assign res_mask       = res_mask_r;
  assign res_round      = res_round_r;
  assign res_sets_flags = res_flags_r;
  assign res_dest_gpr   = res_gpr_r;
  assign res_unknown    = res_unknown_r;

  // =====================================================================
  // events and interrupt
  assign ev[`DPX_EV_UNKNOWN] = req_taken && !cls.info.known;
  assign ev[`DPX_EV_ZDIV]    = req_taken && cls.info.known && mask_nxt[`DPX_EXC_ZDIV];
  assign ev[`DPX_EV_DROPPED] = req_valid && !enabled;

  wire wr_clear  = reg_we && (reg_addr == `DPX_A_CLEAR);
  wire wr_irq_en = reg_we && (reg_addr == `DPX_A_IRQ_EN);
  wire wr_ctrl   = reg_we && (reg_addr == `DPX_A_CTRL);

  dpx_irq #(
    .EV_W (`DPX_EV_W)
  ) u_irq (
    .mclk    (mclk),
    .reset_n (reset_n),
    .ev      (ev),
    .clr_we  (wr_clear),
    .en_we   (wr_irq_en),
    .wdata   (reg_wdata[`DPX_EV_W-1:0]),
    .status  (ev_status),
    .enable  (ev_enable),
    .irq     (irq)
  );

  // =====================================================================
  // register file
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r      <= `DPX_CTRL_RST;
      last_mask_r <= `DPX_M_NONE;
      last_op_r   <= DPX_OP_NONE;
      rdata_r     <= `DPX_ZERO8;
    end else begin
      if (wr_ctrl) ctrl_r <= reg_wdata;
      if (req_taken) begin
        last_mask_r <= mask_nxt;
        last_op_r   <= req_op;
      end
      rdata_r <= rdata_nxt;
    end
  end

  always_comb begin
    rdata_nxt = `DPX_ZERO8;
    if (reg_re) begin
      unique case (reg_addr)
        `DPX_A_STATUS:    rdata_nxt = {{(`DPX_DW-`DPX_EV_W){1'b0}}, ev_status};
        `DPX_A_IRQ_EN:    rdata_nxt = {{(`DPX_DW-`DPX_EV_W){1'b0}}, ev_enable};
        `DPX_A_CTRL:      rdata_nxt = ctrl_r;
        `DPX_A_LAST_MASK: rdata_nxt = {{(`DPX_DW-`DPX_EXC_W){1'b0}}, last_mask_r};
        `DPX_A_LAST_OP:   rdata_nxt = {{(`DPX_DW-$bits(dpx_op_t)){1'b0}}, last_op_r};
        default:          rdata_nxt = `DPX_ZERO8;
      endcase
    end
  end

  assign reg_rdata = rdata_r;

  // =====================================================================
  // assertions
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  add_mask_a: assert property (
    req_taken && req_op == add_packed_double |=> res_valid && res_mask == `DPX_M_ARITH
  ) else $error("packed add mask wrong");

  scalar_add_a: assert property (
    req_taken && req_op == add_scalar_double |=> res_mask == `DPX_M_ARITH && !res_mask[`DPX_EXC_ZDIV]
  ) else $error("scalar add mask wrong");

  logic_empty_a: assert property (
    req_taken && (req_op inside {and_packed_double, and_not_packed_double})
    |=> res_valid && res_mask == `DPX_M_NONE
  ) else $error("bitwise op mask not empty");

  compare_mask_a: assert property (
    req_taken && (req_op inside {compare_packed_double, compare_scalar_double})
    |=> res_mask == `DPX_M_INV_DEN && !res_sets_flags
  ) else $error("predicate compare mask wrong");

  ordered_flags_a: assert property (
    req_taken && req_op == ordered_compare_scalar_double
    |=> res_sets_flags && res_mask == `DPX_M_INV_DEN
  ) else $error("ordered compare wrong");

  int_single_a: assert property (
    req_taken && req_op == int32x4_to_single |=> res_mask == `DPX_M_PRE
  ) else $error("int to single mask wrong");

  rounded_csr_a: assert property (
    req_taken && req_op == single_to_int32x4_rounded
    |=> res_round == $past(csr_round) && res_mask == `DPX_M_INV_PRE
  ) else $error("rounded conversion ignores control rounding");

  trunc_chop_a: assert property (
    req_taken && (req_op inside {single_to_int32x4_truncated, double_to_int32x2_truncated,
                                 double_to_media_int_truncated, double_to_gpr_int_truncated})
    |=> res_round == `DPX_RND_CHOP && res_mask == `DPX_M_INV_PRE
  ) else $error("truncating conversion not chopping");

  int_double_a: assert property (
    req_taken && (req_op inside {int32x2_to_double, media_int_to_double, gpr_int_to_double})
    |=> res_mask == `DPX_M_NONE
  ) else $error("int to double mask not empty");

  gpr_round_a: assert property (
    req_taken && req_op == double_to_gpr_int_rounded
    |=> res_dest_gpr && res_round == $past(csr_round) && res_mask == `DPX_M_INV_PRE
  ) else $error("rounded double to gpr wrong");

  narrow_mask_a: assert property (
    req_taken && (req_op inside {double_to_single_packed, double_to_single_scalar})
    |=> res_mask == `DPX_M_ARITH
  ) else $error("narrowing mask wrong");

  widen_mask_a: assert property (
    req_taken && (req_op inside {single_to_double_packed, single_to_double_scalar})
    |=> res_mask == `DPX_M_INV_DEN
  ) else $error("widening mask wrong");

  divide_irq_a: assert property (
    req_taken && (req_op inside {divide_packed_double, divide_scalar_double})
    |=> res_mask == `DPX_M_ALL ##0 ev_status[`DPX_EV_ZDIV]
  ) else $error("divide mask or event wrong");

  minmax_mask_a: assert property (
    req_taken && (req_op inside {max_packed_double, max_scalar_double,
                                 min_packed_double, min_scalar_double})
    |=> res_mask == `DPX_M_INV_DEN
  ) else $error("min/max mask wrong");

  move_empty_a: assert property (
    req_taken && (req_op inside {move_aligned_packed_double, move_high_half_double,
                                 move_low_half_double, move_scalar_double})
    |=> res_mask == `DPX_M_NONE && !res_dest_gpr
  ) else $error("move mask not empty");

  sign_mask_a: assert property (
    req_taken && req_op == extract_sign_mask_double
    |=> res_mask == `DPX_M_NONE && res_dest_gpr
  ) else $error("sign-mask extraction wrong");

  zdiv_only_div_a: assert property (
    res_valid && res_mask[`DPX_EXC_ZDIV] |-> $past(req_op) inside
      {divide_packed_double, divide_scalar_double}
  ) else $error("divide-by-zero flagged for non-divide");

  drop_no_ans_a: assert property (
    req_valid && !enabled |=> !res_valid ##0 ev_status[`DPX_EV_DROPPED]
  ) else $error("request answered while disabled");

  cov_divide_c: cover property (req_taken && req_op == divide_scalar_double ##1 irq);
  cov_b2b_c:    cover property (req_taken ##1 req_taken ##1 res_valid);
  cov_unknown_c: cover property (req_taken && !cls.info.known ##1 res_unknown);
  cov_trunc_c:  cover property (req_taken && cls.info.chop ##1 res_round == `DPX_RND_CHOP);

endmodule : dpx_top

/* File: rtl/dpx_consts.svh */
`ifndef DPX_CONSTS_SVH
`define DPX_CONSTS_SVH

// =====================================================================
// exception mask bit positions
`define DPX_EXC_W        6
`define DPX_EXC_INV      0
`define DPX_EXC_DEN      1
`define DPX_EXC_ZDIV     2
`define DPX_EXC_OVF      3
`define DPX_EXC_UNF      4
`define DPX_EXC_PRE      5

// =====================================================================
// mask patterns
`define DPX_M_NONE       6'h00
`define DPX_M_ARITH      6'h3b
`define DPX_M_ALL        6'h3f
`define DPX_M_INV_DEN    6'h03
`define DPX_M_INV_PRE    6'h21
`define DPX_M_PRE        6'h20

// =====================================================================
// rounding field
`define DPX_RND_W        2
`define DPX_RND_CHOP     2'h3
`define DPX_RND_RST      2'h0

// =====================================================================
// register map and fields
`define DPX_AW           3
`define DPX_DW           8
`define DPX_A_STATUS     3'h0
`define DPX_A_CLEAR      3'h1
`define DPX_A_IRQ_EN     3'h2
`define DPX_A_CTRL       3'h3
`define DPX_A_LAST_MASK  3'h4
`define DPX_A_LAST_OP    3'h5
`define DPX_EV_W         3
`define DPX_EV_UNKNOWN   0
`define DPX_EV_ZDIV      1
`define DPX_EV_DROPPED   2
`define DPX_CTRL_EN      0
`define DPX_CTRL_RST     8'h01
`define DPX_IRQ_EN_RST   3'h0
`define DPX_ZERO8        8'h00

`endif

/* File: rtl/dpx_pkg.sv */
package dpx_pkg;

  // =====================================================================
  // instruction classes
  typedef enum logic [5:0] {
    DPX_OP_NONE                 = 6'h00,
    add_packed_double           = 6'h01,
    add_scalar_double           = 6'h02,
    and_not_packed_double       = 6'h03,
    and_packed_double           = 6'h04,
    compare_packed_double       = 6'h05,
    compare_scalar_double       = 6'h06,
    ordered_compare_scalar_double = 6'h07,
    int32x4_to_single           = 6'h08,
    single_to_int32x4_rounded   = 6'h09,
    single_to_int32x4_truncated = 6'h0a,
    int32x2_to_double           = 6'h0b,
    double_to_int32x2_rounded   = 6'h0c,
    double_to_media_int_rounded = 6'h0d,
    double_to_single_packed     = 6'h0e,
    media_int_to_double         = 6'h0f,
    single_to_double_packed     = 6'h10,
    double_to_gpr_int_rounded   = 6'h11,
    double_to_single_scalar     = 6'h12,
    gpr_int_to_double           = 6'h13,
    single_to_double_scalar     = 6'h14,
    double_to_int32x2_truncated = 6'h15,
    double_to_media_int_truncated = 6'h16,
    double_to_gpr_int_truncated = 6'h17,
    divide_packed_double        = 6'h18,
    divide_scalar_double        = 6'h19,
    max_packed_double           = 6'h1a,
    max_scalar_double           = 6'h1b,
    min_packed_double           = 6'h1c,
    min_scalar_double           = 6'h1d,
    move_aligned_packed_double  = 6'h1e,
    move_high_half_double       = 6'h1f,
    move_low_half_double        = 6'h20,
    extract_sign_mask_double    = 6'h21,
    move_scalar_double          = 6'h22
  } dpx_op_t;

  // =====================================================================
  // classification result
  typedef struct packed {
    logic       known;
    logic [5:0] mask;
    logic       chop;
    logic       sets_flags;
    logic       dest_gpr;
  } dpx_info_t;

endpackage : dpx_pkg

/* File: rtl/dpx_cls_if.sv */
`timescale 1ns/1ps

interface dpx_cls_if;
  import dpx_pkg::*;
  dpx_op_t   op;
  dpx_info_t info;
  modport dec  (input op, output info);
  modport user (output op, input info);
endinterface : dpx_cls_if

/* File: rtl/dpx_decode.sv */
`timescale 1ns/1ps
`include "dpx_consts.svh"

module dpx_decode (
  // class in, classification out
  dpx_cls_if.dec cls
);
  import dpx_pkg::*;

  // =====================================================================
  // classification table
  function automatic dpx_info_t dpx_classify(input dpx_op_t op);
    dpx_info_t r;
    r = '{known: 1'b1, mask: `DPX_M_NONE, chop: 1'b0, sets_flags: 1'b0, dest_gpr: 1'b0};
    unique case (op)
      add_packed_double,
      add_scalar_double:             r.mask = `DPX_M_ARITH;
      and_not_packed_double,
      and_packed_double:             r.mask = `DPX_M_NONE;
      compare_packed_double,
      compare_scalar_double:         r.mask = `DPX_M_INV_DEN;
      ordered_compare_scalar_double: begin
        r.mask       = `DPX_M_INV_DEN;
        r.sets_flags = 1'b1;
      end
      int32x4_to_single:             r.mask = `DPX_M_PRE;
      single_to_int32x4_rounded:     r.mask = `DPX_M_INV_PRE;
      single_to_int32x4_truncated,
      double_to_int32x2_truncated,
      double_to_media_int_truncated: begin
        r.mask = `DPX_M_INV_PRE;
        r.chop = 1'b1;
      end
      double_to_gpr_int_truncated: begin
        r.mask     = `DPX_M_INV_PRE;
        r.chop     = 1'b1;
        r.dest_gpr = 1'b1;
      end
      int32x2_to_double,
      media_int_to_double,
      gpr_int_to_double:             r.mask = `DPX_M_NONE;
      double_to_int32x2_rounded,
      double_to_media_int_rounded:   r.mask = `DPX_M_INV_PRE;
      double_to_gpr_int_rounded: begin
        r.mask     = `DPX_M_INV_PRE;
        r.dest_gpr = 1'b1;
      end
      double_to_single_packed,
      double_to_single_scalar:       r.mask = `DPX_M_ARITH;
      single_to_double_packed,
      single_to_double_scalar:       r.mask = `DPX_M_INV_DEN;
      divide_packed_double,
      divide_scalar_double:          r.mask = `DPX_M_ALL;
      max_packed_double, max_scalar_double,
      min_packed_double, min_scalar_double:
                                     r.mask = `DPX_M_INV_DEN;
      move_aligned_packed_double, move_high_half_double,
      move_low_half_double, move_scalar_double:
                                     r.mask = `DPX_M_NONE;
      extract_sign_mask_double: begin
        r.mask     = `DPX_M_NONE;
        r.dest_gpr = 1'b1;
      end
      default:                       r.known = 1'b0;
    endcase
    return r;
  endfunction : dpx_classify

  assign cls.info = dpx_classify(cls.op);

endmodule : dpx_decode

/* File: rtl/dpx_irq.sv */
`timescale 1ns/1ps
`include "dpx_consts.svh"

module dpx_irq #(
  parameter int EV_W = `DPX_EV_W
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            reset_n,
  // events
  input  wire logic [EV_W-1:0] ev,
  // software access
  input  wire logic            clr_we,
  input  wire logic            en_we,
  input  wire logic [EV_W-1:0] wdata,
  // state
  output logic      [EV_W-1:0] status,
  output logic      [EV_W-1:0] enable,
  output logic                 irq
);

  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] status_nxt;
  logic [EV_W-1:0] enable_r;
  wire  [EV_W-1:0] clr_bits = clr_we ? wdata : '0;

  // a set in the cycle of its clear wins
  assign status_nxt = (status_r & ~clr_bits) | ev;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= '0;
      enable_r <= `DPX_IRQ_EN_RST;
    end else begin
      status_r <= status_nxt;
      if (en_we) enable_r <= wdata;
    end
  end

  assign status = status_r;
  assign enable = enable_r;
  assign irq    = |(status_r & enable_r);

endmodule : dpx_irq

/* File: tb/dpx_pipe_model.sv */
`timescale 1ns/1ps
`include "dpx_consts.svh"

module dpx_pipe_model (
  // clock
  input  wire logic                  mclk,
  // request side
  output logic                       req_valid,
  output dpx_pkg::dpx_op_t           req_op,
  output logic [`DPX_RND_W-1:0]      csr_round,
  // answer side
  input  wire logic                  res_valid
);
  import dpx_pkg::*;

  int n_answers = 0;

  initial begin
    req_valid = 1'b0;
    req_op    = DPX_OP_NONE;
    csr_round = 2'h0;
  end

  // =====================================================================
  // request driver: idle class lines flip so a stale value is never read
  task automatic drive(input logic v, input dpx_op_t op, input logic [1:0] r);
    req_valid <= v;
    req_op    <= v ? op : dpx_op_t'(~req_op);
    csr_round <= v ? r : ~csr_round;
  endtask : drive

  // =====================================================================
  // answer counter
  always @(posedge mclk) begin
    if (res_valid === 1'b1) begin
      n_answers <= n_answers + 1;
    end
  end
endmodule : dpx_pipe_model

/* File: tb/tb_dp_simd_fp_exception_map.sv */
`timescale 1ns/1ps
`include "dpx_consts.svh"

module tb_dp_simd_fp_exception_map;
  import dpx_pkg::*;

  typedef struct packed {
    dpx_op_t    op;
    logic [5:0] m;
    logic [2:0] fl;
  } dpx_tb_row_t;

  localparam int N_ROWS = 34;

  // =====================================================================
  // class table: op, mask, {chop, sets flags, dest gpr}
  dpx_tb_row_t rows [N_ROWS] = '{
    {add_packed_double,             6'h3b, 3'b000},
    {add_scalar_double,             6'h3b, 3'b000},
    {and_not_packed_double,         6'h00, 3'b000},
    {and_packed_double,             6'h00, 3'b000},
    {compare_packed_double,         6'h03, 3'b000},
    {compare_scalar_double,         6'h03, 3'b000},
    {ordered_compare_scalar_double, 6'h03, 3'b010},
    {int32x4_to_single,             6'h20, 3'b000},
    {single_to_int32x4_rounded,     6'h21, 3'b000},
    {single_to_int32x4_truncated,   6'h21, 3'b100},
    {int32x2_to_double,             6'h00, 3'b000},
    {double_to_int32x2_rounded,     6'h21, 3'b000},
    {double_to_media_int_rounded,   6'h21, 3'b000},
    {double_to_single_packed,       6'h3b, 3'b000},
    {media_int_to_double,           6'h00, 3'b000},
    {single_to_double_packed,       6'h03, 3'b000},
    {double_to_gpr_int_rounded,     6'h21, 3'b001},
    {double_to_single_scalar,       6'h3b, 3'b000},
    {gpr_int_to_double,             6'h00, 3'b000},
    {single_to_double_scalar,       6'h03, 3'b000},
    {double_to_int32x2_truncated,   6'h21, 3'b100},
    {double_to_media_int_truncated, 6'h21, 3'b100},
    {double_to_gpr_int_truncated,   6'h21, 3'b101},
    {divide_packed_double,          6'h3f, 3'b000},
    {divide_scalar_double,          6'h3f, 3'b000},
    {max_packed_double,             6'h03, 3'b000},
    {max_scalar_double,             6'h03, 3'b000},
    {min_packed_double,             6'h03, 3'b000},
    {min_scalar_double,             6'h03, 3'b000},
    {move_aligned_packed_double,    6'h00, 3'b000},
    {move_high_half_double,         6'h00, 3'b000},
    {move_low_half_double,          6'h00, 3'b000},
    {extract_sign_mask_double,      6'h00, 3'b001},
    {move_scalar_double,            6'h00, 3'b000}
  };

  // =====================================================================
  // signals
  logic        mclk = 1'b0;
  logic        reset_n;
  logic        req_valid;
  dpx_op_t     req_op;
  logic [1:0]  csr_round;
  logic        res_valid;
  logic [5:0]  res_mask;
  logic [1:0]  res_round;
  logic        res_sets_flags;
  logic        res_dest_gpr;
  logic        res_unknown;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_we;
  logic        reg_re;
  logic [7:0]  reg_rdata;
  logic        irq;
  int          miscompares;
  int          n_tests;
  int          i;
  int          n0;
  logic [1:0]  rnd;

  always #20 mclk = ~mclk;

  dpx_top i_dut (
    .mclk(mclk), .reset_n(reset_n), .req_valid(req_valid), .req_op(req_op),
    .csr_round(csr_round), .res_valid(res_valid), .res_mask(res_mask),
    .res_round(res_round), .res_sets_flags(res_sets_flags), .res_dest_gpr(res_dest_gpr),
    .res_unknown(res_unknown), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq)
  );

  dpx_pipe_model i_pipe (
    .mclk(mclk), .req_valid(req_valid), .req_op(req_op), .csr_round(csr_round),
    .res_valid(res_valid)
  );

  // =====================================================================
  // checking and closing
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // =====================================================================
  // request and register tasks
  task automatic send(input dpx_op_t op, input logic [1:0] r);
    @(posedge mclk);
    i_pipe.drive(1'b1, op, r);
    @(posedge mclk);
    i_pipe.drive(1'b0, op, r);
    #1;
  endtask : send

  task automatic wait_ans();
    for (int k = 0; k < 4 && res_valid !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    if (res_valid !== 1'b1) begin
      miscompares++;
      $display("mismatch res_valid expected 1 seen %b", res_valid);
      final_report();
    end
  endtask : wait_ans

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_we    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we    <= 1'b0;
  endtask : reg_wr

  task automatic reg_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk);
    reg_re   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re   <= 1'b0;
    #1;
    chk(what, reg_rdata, exp);
  endtask : reg_chk

  // =====================================================================
  // main sequence
  initial begin
    reset_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk("res_valid", 8'(res_valid), 8'h00);
    chk("res_mask", 8'(res_mask), 8'h00);
    chk("irq", 8'(irq), 8'h00);
    reg_chk(`DPX_A_CTRL, `DPX_CTRL_RST, "ctrl");
    // read data stands for one cycle only
    @(posedge mclk);
    #1;
    chk("rdata idle", reg_rdata, 8'h00);
    reg_chk(`DPX_A_IRQ_EN, 8'h00, "irq_en");
    reg_chk(`DPX_A_STATUS, 8'h00, "status");
    reg_chk(3'h6, 8'h00, "unmapped");
    $display("test reset done");

    for (i = 0; i < N_ROWS; i++) begin
      rnd = i[0] ? 2'h1 : 2'h2;
      send(rows[i].op, rnd);
      wait_ans();
      chk("mask", 8'(res_mask), 8'(rows[i].m));
      chk("round", 8'(res_round), 8'(rows[i].fl[2] ? `DPX_RND_CHOP : rnd));
      chk("sets_flags", 8'(res_sets_flags), 8'(rows[i].fl[1]));
      chk("dest_gpr", 8'(res_dest_gpr), 8'(rows[i].fl[0]));
      chk("unknown", 8'(res_unknown), 8'h00);
    end
    $display("test class table done");

    send(dpx_op_t'(6'h3f), 2'h0);
    wait_ans();
    chk("unknown mask", 8'(res_mask), 8'h00);
    chk("unknown", 8'(res_unknown), 8'h01);
    reg_chk(`DPX_A_STATUS, 8'h03, "status");
    $display("test unknown class done");

    // back to back: divide then and-not, one per cycle
    @(posedge mclk);
    i_pipe.drive(1'b1, divide_scalar_double, 2'h0);
    @(posedge mclk);
    i_pipe.drive(1'b1, and_not_packed_double, 2'h0);
    #1;
    chk("b2b valid 1", 8'(res_valid), 8'h01);
    chk("b2b mask 1", 8'(res_mask), 8'h3f);
    @(posedge mclk);
    i_pipe.drive(1'b0, DPX_OP_NONE, 2'h0);
    #1;
    chk("b2b valid 2", 8'(res_valid), 8'h01);
    chk("b2b mask 2", 8'(res_mask), 8'h00);
    @(posedge mclk);
    #1;
    chk("b2b valid 3", 8'(res_valid), 8'h00);
    chk("b2b mask held", 8'(res_mask), 8'h00);
    $display("test back to back done");

    reg_wr(`DPX_A_CLEAR, 8'h07);
    reg_chk(`DPX_A_STATUS, 8'h00, "status cleared");
    reg_wr(`DPX_A_STATUS, 8'h07);
    reg_chk(`DPX_A_STATUS, 8'h00, "status read only");
    reg_wr(`DPX_A_IRQ_EN, 8'h02);
    reg_chk(`DPX_A_IRQ_EN, 8'h02, "irq_en");
    chk("irq idle", 8'(irq), 8'h00);
    send(divide_packed_double, 2'h0);
    wait_ans();
    chk("irq raised", 8'(irq), 8'h01);
    reg_wr(`DPX_A_IRQ_EN, 8'h00);
    #1;
    chk("irq masked", 8'(irq), 8'h00);
    reg_wr(`DPX_A_IRQ_EN, 8'h02);
    #1;
    chk("irq unmasked", 8'(irq), 8'h01);
    reg_wr(`DPX_A_CLEAR, 8'h02);
    #1;
    chk("irq cleared", 8'(irq), 8'h00);
    $display("test interrupt done");

    reg_wr(`DPX_A_CTRL, 8'h00);
    reg_chk(`DPX_A_CTRL, 8'h00, "ctrl off");
    n0 = i_pipe.n_answers;
    send(add_scalar_double, 2'h0);
    repeat (3) @(posedge mclk);
    #1;
    chk("refused answers", 8'(i_pipe.n_answers - n0), 8'h00);
    chk("refused mask held", 8'(res_mask), 8'h3f);
    reg_chk(`DPX_A_STATUS, 8'h04, "status dropped");
    reg_chk(`DPX_A_CLEAR, 8'h00, "clear reads zero");
    // a drop in the cycle of its own clear must survive the clear
    @(posedge mclk);
    i_pipe.drive(1'b1, add_scalar_double, 2'h0);
    reg_we    <= 1'b1;
    reg_addr  <= `DPX_A_CLEAR;
    reg_wdata <= 8'h04;
    @(posedge mclk);
    i_pipe.drive(1'b0, add_scalar_double, 2'h0);
    reg_we    <= 1'b0;
    reg_chk(`DPX_A_STATUS, 8'h04, "status set wins");
    reg_wr(`DPX_A_CTRL, 8'h01);
    send(add_scalar_double, 2'h0);
    wait_ans();
    chk("add mask", 8'(res_mask), 8'h3b);
    reg_chk(`DPX_A_LAST_MASK, 8'h3b, "last mask");
    reg_chk(`DPX_A_LAST_OP, 8'(add_scalar_double), "last op");
    $display("test refused request done");

    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk("reset mask", 8'(res_mask), 8'h00);
    chk("reset irq", 8'(irq), 8'h00);
    @(posedge mclk);
    reset_n <= 1'b1;
    reg_chk(`DPX_A_CTRL, `DPX_CTRL_RST, "ctrl after reset");
    reg_chk(`DPX_A_STATUS, 8'h00, "status after reset");
    send(double_to_single_scalar, 2'h2);
    wait_ans();
    chk("narrow mask", 8'(res_mask), 8'h3b);
    $display("test mid-run reset done");
    final_report();
  end
endmodule : tb_dp_simd_fp_exception_map
